//--- sdrtz_defs.vh
// Purpose: constants for the stall detector return-to-zero control block
// Assumes: axi4-lite byte offsets are four times the register index
// Notes:   definitions only
`ifndef SDRTZ_DEFS_VH
`define SDRTZ_DEFS_VH

// register indices and address width
`define SDRTZ_IDX_RTZ_CONTROL      3'h0
`define SDRTZ_IDX_DC_CONTROL       3'h1
`define SDRTZ_IDX_SD_CONTROL       3'h2
`define SDRTZ_IDX_SD_FLAGS         3'h3
`define SDRTZ_IDX_DC_HIGH          3'h4
`define SDRTZ_IDX_DC_LOW           3'h5
`define SDRTZ_IDX_ACC_HIGH         3'h6
`define SDRTZ_IDX_ACC_LOW          3'h7
`define SDRTZ_IDX_IRQ_STATUS       4'h8
`define SDRTZ_IDX_IRQ_MASK         4'h9
`define SDRTZ_IDX_CONFIG           4'ha
`define SDRTZ_ADDR_BITS            6

// rtz_control fields
`define SDRTZ_BIT_INTEGRATE        7
`define SDRTZ_BIT_DRIVE            6
`define SDRTZ_BIT_RECIRC           5
`define SDRTZ_BIT_POLARITY         4
`define SDRTZ_BIT_MOTOR            2
`define SDRTZ_STEP_HI              1
`define SDRTZ_STEP_LO              0

// down_counter_control fields
`define SDRTZ_BIT_DC_LOAD          3
`define SDRTZ_BIT_DC_ENABLE        2
`define SDRTZ_BIT_DC_MODULUS       6
`define SDRTZ_BIT_DC_PRESCALE      4

// interrupt status bits
`define SDRTZ_IRQ_UNDERFLOW        0
`define SDRTZ_IRQ_OVERFLOW         1

// config register: return_to_zero_enable
`define SDRTZ_BIT_RTZ_ENABLE       0

// reset values
`define SDRTZ_RST_BYTE             8'h00
`define SDRTZ_RST_COUNT            16'hffff

// prescaler: bus clock divided by 64 or 512
`define SDRTZ_PRESCALE_SHORT       9'd63
`define SDRTZ_PRESCALE_LONG        9'd511

// axi responses
`define SDRTZ_RESP_OKAY            2'b00
`define SDRTZ_RESP_SLVERR          2'b10

`endif

//--- sdrtz_top.v
// Purpose: stall detector return-to-zero control, bridge and switch decode
// Assumes: axi4-lite slave, one clock, synchronous active-low reset
// Notes:   converter is outside; this block feeds it reset and takes its bit
//
// Summary of operation
// - bit 7 set integrates with undriven coil floating, clear blanks it
// - integrate clear holds converter reset and zeroes accumulator
// - integrate set routes undriven coil to reference and integrator
// - bit 6 drives the step coil when set, switches it off when clear
// - bit 5 picks recirculation: high side at 0, low side at 1
// - bit 4 picks which undriven coil end goes to the converter
// - bit 2 routes detection to motor a at 0, motor b at 1
// - step field bits 1:0: east, north, west, south poles
// - integrate with drive off turns all eight transistors off
// - driven pair: t1/t4, t5/t8, t2/t3, t6/t7 for steps 0..3
// - blanking pair on other coil, high or low side per recirculation
// - integrating keeps every undriven coil transistor off
// - integrate only after blanking into a 16-bit readable accumulator
// - 16-bit modulus down counter with interrupt times the intervals
// - eight byte registers; accumulator bytes read-only, others read/write
// - switches open when integrate clear, else chosen by step and polarity
//
// Chosen here: the AXI4-Lite register port.
`include "sdrtz_defs.vh"
`default_nettype none

module sdrtz_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        conv_bit,
  output reg  [7:0]  bridge_on_a,
  output reg  [7:0]  bridge_on_b,
  output reg         bridge_own_a,
  output reg         bridge_own_b,
  output reg  [7:0]  switch_close_a,
  output reg  [7:0]  switch_close_b,
  output reg         conv_reset,
  output reg         irq
);

  // register file
  reg  [7:0]  rtz_control_r;
  reg  [7:0]  dc_control_r;
  reg  [7:0]  sd_control_r;
  reg  [7:0]  sd_flags_r;
  reg  [15:0] dc_load_r;
  reg  [15:0] dc_count_r;
  reg  [15:0] acc_r;
  reg  [1:0]  irq_status_r;
  reg  [1:0]  irq_mask_r;
  reg         rtz_enable_r;
  reg  [8:0]  pre_cnt_r;
  reg         integrate_go_r;

  // axi write side holding
  reg  [5:0]  aw_addr_r;
  reg         aw_have_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_have_r;

  wire        integrate = rtz_control_r[`SDRTZ_BIT_INTEGRATE];
  wire        drive     = rtz_control_r[`SDRTZ_BIT_DRIVE];
  wire        recirc    = rtz_control_r[`SDRTZ_BIT_RECIRC];
  wire        integration_polarity       = rtz_control_r[`SDRTZ_BIT_POLARITY];
  wire        motor_b   = rtz_control_r[`SDRTZ_BIT_MOTOR];
  wire [1:0]  step      = rtz_control_r[1:0];

  // blanking pair sits on the coil that the step leaves undriven
  // integrating floats that coil, so its pair is masked off there
  // pairs never share a leg of one half bridge: no shoot-through
  // transistor decode per step, integrate, drive and recirculation
  function [7:0] tr_decode;
    input [1:0] st;
    input       integrate_select;
    input       drive_coil_enable;
    input       rc;
    reg   [7:0] drv;
    reg   [7:0] blk;
    begin
      drv = 8'h00;
      blk = 8'h00;
      // bit n-1 is transistor tn
      case (st)
        2'd0: drv = 8'b0000_1001;
        2'd1: drv = 8'b1001_0000;
        2'd2: drv = 8'b0000_0110;
        2'd3: drv = 8'b0110_0000;
        default: drv = 8'h00;
      endcase
      // sine coil blanks for steps 0/2, cosine coil for 1/3
      if (st[0] == 1'b0) begin
        blk = rc ? 8'b1010_0000 : 8'b0101_0000;
      end else begin
        blk = rc ? 8'b0000_1010 : 8'b0000_0101;
      end
      tr_decode = (drive_coil_enable ? drv : 8'h00)
                | (integrate_select ? 8'h00 : blk);
    end
  endfunction

  // even steps route the sine coil, odd steps the cosine coil
  // steps 2 and 3 swap ends, as the coil current is reversed there
  // all switches open whenever integrate is clear
  // converter routing switch decode, bit n-1 is switch sn
  function [7:0] sw_decode;
    input [1:0] st;
    input       integrate_select;
    input       pl;
    reg         sel;
    begin
      sel = pl ^ st[1];
      if (!integrate_select) begin
        sw_decode = 8'h00;
      end else if (st[0] == 1'b0) begin
        sw_decode = sel ? 8'b0110_0000 : 8'b1001_0000;
      end else begin
        sw_decode = sel ? 8'b0000_1001 : 8'b0000_0110;
      end
    end
  endfunction

  wire [7:0] tr_nxt = tr_decode(step, integrate, drive, recirc);
  wire [7:0] sw_nxt = sw_decode(step, integrate, integration_polarity);

  // strobe lane 0 alone carries the byte; upper lanes are ignored
  // accumulator bytes answer slverr and keep their value
  // bvalid blocks a second commit until the answer is taken
  // write decode: commit when both address and data are held
  wire        wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [3:0]  wr_idx  = aw_addr_r[5:2];
  wire [7:0]  wr_byte = w_data_r[7:0];
  wire        wr_lane = w_strb_r[0];
  wire        wr_ok   = (wr_idx <= `SDRTZ_IDX_CONFIG)
                     && (wr_idx != {1'b0, `SDRTZ_IDX_ACC_HIGH})
                     && (wr_idx != {1'b0, `SDRTZ_IDX_ACC_LOW});

  function wr_hit;
    input [3:0] idx;
    begin
      wr_hit = wr_go && wr_lane && (wr_idx == idx);
    end
  endfunction

  // prescaler counts bus clocks; its wrap is the one-cycle tick
  // a rate change acts at once: >= keeps a shrink from overshooting
  // force load is a write strobe, never stored
  // down counter tick from prescaler enable pulse
  wire dc_en   = dc_control_r[`SDRTZ_BIT_DC_ENABLE];
  wire [8:0] pre_top = dc_control_r[`SDRTZ_BIT_DC_PRESCALE] ?
                       `SDRTZ_PRESCALE_LONG : `SDRTZ_PRESCALE_SHORT;
  wire dc_tick = dc_en && (pre_cnt_r >= pre_top);
  wire dc_zero_hit = dc_tick && (dc_count_r == 16'h0001);
  wire force_load = wr_hit({1'b0, `SDRTZ_IDX_DC_CONTROL})
                 && wr_byte[`SDRTZ_BIT_DC_LOAD];
  wire acc_ovf = integrate && integrate_go_r && conv_bit
              && (acc_r == 16'hffff);
  wire [1:0] irq_ev = {acc_ovf, dc_zero_hit};

  // ready pulses for one cycle, then stays low while a beat is held
  // address and data may arrive in either order
  // trade-off: one write in flight keeps the decode simple
  // axi handshake: one write and one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SDRTZ_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 6'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SDRTZ_RESP_OKAY : `SDRTZ_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // enable and force load in one write: the load is lost, as the
  // counter still sees itself disabled on that edge
  // software enables first, then loads
  // register writes; no access restriction on rtz_control
  always @(posedge aclk) begin
    if (!aresetn) begin
      rtz_control_r <= `SDRTZ_RST_BYTE;
      dc_control_r  <= `SDRTZ_RST_BYTE;
      sd_control_r  <= `SDRTZ_RST_BYTE;
      sd_flags_r    <= `SDRTZ_RST_BYTE;
      dc_load_r     <= `SDRTZ_RST_COUNT;
      irq_mask_r    <= 2'b00;
      rtz_enable_r  <= 1'b0;
    end else begin
      if (wr_hit({1'b0, `SDRTZ_IDX_RTZ_CONTROL}))
        rtz_control_r <= wr_byte & 8'hf7;
      if (wr_hit({1'b0, `SDRTZ_IDX_DC_CONTROL}))
        dc_control_r <= wr_byte & 8'hf5;  // load bit reads zero
      if (wr_hit({1'b0, `SDRTZ_IDX_SD_CONTROL}))
        sd_control_r <= wr_byte;
      if (wr_hit({1'b0, `SDRTZ_IDX_SD_FLAGS}))
        sd_flags_r <= wr_byte;
      if (wr_hit({1'b0, `SDRTZ_IDX_DC_HIGH}))
        dc_load_r[15:8] <= wr_byte;
      if (wr_hit({1'b0, `SDRTZ_IDX_DC_LOW}))
        dc_load_r[7:0] <= wr_byte;
      if (wr_hit(`SDRTZ_IDX_IRQ_MASK))
        irq_mask_r <= wr_byte[1:0];
      if (wr_hit(`SDRTZ_IDX_CONFIG))
        rtz_enable_r <= wr_byte[`SDRTZ_BIT_RTZ_ENABLE];
    end
  end

  // the step from one to zero is the underflow event
  // a count of zero without modulus mode just sits there
  // hazard: reload uses the load register as written right now
  // modulus down counter; disabled presets all ones to avoid early flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      dc_count_r <= `SDRTZ_RST_COUNT;
      pre_cnt_r  <= 9'd0;
    end else if (!dc_en) begin
      dc_count_r <= `SDRTZ_RST_COUNT;
      pre_cnt_r  <= 9'd0;
    end else if (force_load) begin
      dc_count_r <= dc_load_r;
      pre_cnt_r  <= 9'd0;
    end else if (dc_tick) begin
      pre_cnt_r <= 9'd0;
      if (dc_count_r == 16'h0001 || dc_count_r == 16'h0000) begin
        // modulus mode reloads, else the counter sticks at zero
        dc_count_r <= dc_control_r[`SDRTZ_BIT_DC_MODULUS] ?
                      dc_load_r : 16'h0000;
      end else begin
        dc_count_r <= dc_count_r - 16'h0001;
      end
    end else begin
      pre_cnt_r <= pre_cnt_r + 9'd1;
    end
  end

  // first integrate cycle still clears: the boundary after blanking
  // a stale converter bit from reset must never land in the count
  // overflow wraps to zero and only raises the flag
  // accumulator: cleared while blanking, counts converter ones after
  always @(posedge aclk) begin
    if (!aresetn) begin
      acc_r          <= 16'h0000;
      integrate_go_r <= 1'b0;
      conv_reset     <= 1'b1;
    end else begin
      conv_reset     <= !integrate;
      integrate_go_r <= integrate;
      if (!integrate || !integrate_go_r) begin
        acc_r <= 16'h0000;
      end else if (conv_bit) begin
        acc_r <= acc_r + 16'h0001;
      end
    end
  end

  // an event in the cycle of a clear still leaves its bit set
  // irq looks ahead at the event so it rises with the status bit
  // sticky interrupt status; set wins over write-one clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_r <= 2'b00;
      irq          <= 1'b0;
    end else begin
      if (wr_hit(`SDRTZ_IDX_IRQ_STATUS))
        irq_status_r <= (irq_status_r & ~wr_byte[1:0]) | irq_ev;
      else
        irq_status_r <= irq_status_r | irq_ev;
      irq <= |((irq_status_r | irq_ev) & irq_mask_r);
    end
  end

  // switches stay live without enable so software can convert
  // while the normal driver still owns the coil pins
  // bridge outputs are zero whenever this block does not own them
  // bridge and switch outputs for the selected motor
  always @(posedge aclk) begin
    if (!aresetn) begin
      bridge_on_a    <= 8'h00;
      bridge_on_b    <= 8'h00;
      bridge_own_a   <= 1'b0;
      bridge_own_b   <= 1'b0;
      switch_close_a <= 8'h00;
      switch_close_b <= 8'h00;
    end else begin
      // disabled: hand the pins back to the normal motor driver
      bridge_own_a   <= rtz_enable_r && !motor_b;
      bridge_own_b   <= rtz_enable_r && motor_b;
      bridge_on_a    <= (rtz_enable_r && !motor_b) ? tr_nxt : 8'h00;
      bridge_on_b    <= (rtz_enable_r && motor_b) ? tr_nxt : 8'h00;
      switch_close_a <= motor_b ? 8'h00 : sw_nxt;
      switch_close_b <= motor_b ? sw_nxt : 8'h00;
    end
  end

  // read data is captured at the address handshake
  // unmapped indices read zero with slverr
  // read channel: one cycle after address taken
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[5:2])
      {1'b0, `SDRTZ_IDX_RTZ_CONTROL}: rd_val[7:0] = rtz_control_r;
      {1'b0, `SDRTZ_IDX_DC_CONTROL}:  rd_val[7:0] = dc_control_r;
      {1'b0, `SDRTZ_IDX_SD_CONTROL}:  rd_val[7:0] = sd_control_r;
      {1'b0, `SDRTZ_IDX_SD_FLAGS}:    rd_val[7:0] = sd_flags_r;
      {1'b0, `SDRTZ_IDX_DC_HIGH}:     rd_val[7:0] = dc_count_r[15:8];
      {1'b0, `SDRTZ_IDX_DC_LOW}:      rd_val[7:0] = dc_count_r[7:0];
      {1'b0, `SDRTZ_IDX_ACC_HIGH}:    rd_val[7:0] = acc_r[15:8];
      {1'b0, `SDRTZ_IDX_ACC_LOW}:     rd_val[7:0] = acc_r[7:0];
      `SDRTZ_IDX_IRQ_STATUS:          rd_val[1:0] = irq_status_r;
      `SDRTZ_IDX_IRQ_MASK:            rd_val[1:0] = irq_mask_r;
      `SDRTZ_IDX_CONFIG:              rd_val[0]   = rtz_enable_r;
      default:                        rd_val = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SDRTZ_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= (s_axi_araddr[5:2] <= `SDRTZ_IDX_CONFIG) ?
                        `SDRTZ_RESP_OKAY : `SDRTZ_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sdrtz_top
`default_nettype wire

//--- sdrtz_props.sv
// Purpose: port assertions for the return-to-zero control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to sdrtz_top; sees its ports only
`default_nettype none
module sdrtz_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  bridge_on_a,
  input wire logic [7:0]  bridge_on_b,
  input wire logic        bridge_own_a,
  input wire logic        bridge_own_b,
  input wire logic [7:0]  switch_close_a,
  input wire logic [7:0]  switch_close_b,
  input wire logic        conv_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus handshakes that start an answer
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence w_taken; s_axi_wvalid && s_axi_wready; endsequence
  motor_own_a: assert property (!(bridge_own_a && bridge_own_b))
    else $error("both bridges owned");
  idle_bridge_a: assert property ((!bridge_own_a |-> bridge_on_a == 8'h00)
    and (!bridge_own_b |-> bridge_on_b == 8'h00)) else $error("idle bridge on");
  open_switch_a: assert property (conv_reset |->
    (switch_close_a | switch_close_b) == 8'h00) else $error("switch closed");
  switch_pair_a: assert property (switch_close_a != 8'h00 |->
    switch_close_a inside {8'h90, 8'h60, 8'h06, 8'h09}
    && switch_close_b == 8'h00) else $error("bad switch pair");
  float_coil_a: assert property ((!(|switch_close_a[7:4]) ||
    bridge_on_a[7:4] == 4'h0) && (!(|switch_close_a[3:0]) ||
    bridge_on_a[3:0] == 4'h0)) else $error("undriven coil conducts");
  no_shoot_a: assert property (((bridge_on_a | bridge_on_b) &
    ((bridge_on_a | bridge_on_b) >> 1) & 8'h55) == 8'h00) else $error("leg short");
  reset_idle_a: assert property ($rose(aresetn) |-> conv_reset
    && !bridge_own_a && !bridge_own_b) else $error("not idle after reset");
  read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("late read answer");
  write_answer_a: assert property (w_taken |-> ##[1:4] s_axi_bvalid)
    else $error("late write answer");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule // sdrtz_props
bind sdrtz_top sdrtz_props u_sdrtz_props (.aclk, .aresetn, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bridge_on_a, .bridge_on_b,
  .bridge_own_a, .bridge_own_b, .switch_close_a, .switch_close_b, .conv_reset);
`default_nettype wire

//--- sdrtz_coil_model.sv
// Purpose: coil and converter stand-in for the return-to-zero block
// Assumes: a routed undriven coil always shows back voltage
// Notes:   output wanders while the converter is held
`default_nettype none
module sdrtz_coil_model (
  input wire logic       aclk,
  input wire logic       conv_reset,
  input wire logic [7:0] switch_close_a,
  input wire logic [7:0] switch_close_b,
  output logic           conv_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tog_r = 1'b0;
  // held converter: toggles so a stale bit is never trusted
  always @(posedge aclk) tog_r <= !tog_r;
  // released: ones only while a coil end reaches the integrator
  assign conv_bit = conv_reset ? tog_r : |(switch_close_a | switch_close_b);
endmodule // sdrtz_coil_model
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the return-to-zero control block
// Assumes: register byte address is four times the index
// Notes:   random control bytes plus fixed corner sweeps
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, conv_bit, conv_reset, irq;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  bridge_on_a, bridge_on_b, switch_close_a, switch_close_b, c, e;
  logic        bridge_own_a, bridge_own_b, en;
  int          fail_count = 0, checks = 0, i, n;
  sdrtz_top u_sdrtz_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv_bit, .bridge_on_a, .bridge_on_b, .bridge_own_a, .bridge_own_b,
    .switch_close_a, .switch_close_b, .conv_reset, .irq);
  sdrtz_coil_model u_sdrtz_coil_model (.aclk, .conv_reset, .switch_close_a,
    .switch_close_b, .conv_bit);
  initial forever #5 aclk = ~aclk;
  task automatic test_done;
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one write; both channels offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_bready <= 1;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    for (k = 0; k < 64 && !s_axi_bvalid; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    r = s_axi_bresp; s_axi_bready <= 0;
    if (k == 64) begin fail_count++; test_done; end
  endtask
  task automatic rd(input logic [5:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    s_axi_rready <= 1'($urandom); // sometimes late, to stall the answer
    for (k = 0; k < 64 && !(s_axi_rvalid && s_axi_rready); k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    if (k == 64) begin fail_count++; test_done; end
  endtask
  // transistors on: driven pair plus blanking pair on the other coil
  function automatic logic [7:0] exp_br(input logic [7:0] v);
    logic [7:0] dp, bp;
    case (v[1:0])
      2'd0: dp = 8'h09;
      2'd1: dp = 8'h90;
      2'd2: dp = 8'h06;
      default: dp = 8'h60;
    endcase
    bp = v[0] ? (v[5] ? 8'h0a : 8'h05) : (v[5] ? 8'ha0 : 8'h50);
    return (v[6] ? dp : 8'h00) | (v[7] ? 8'h00 : bp);
  endfunction
  // converter switches: polarity flips on steps 2 and 3
  function automatic logic [7:0] exp_sw(input logic [7:0] v);
    logic p;
    p = v[4] ^ v[1];
    if (!v[7]) return 8'h00;
    return v[0] ? (p ? 8'h09 : 8'h06) : (p ? 8'h60 : 8'h90);
  endfunction
  initial begin
    void'($urandom(93901));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(6'h00); chk(d, 32'h0000_0000);
    rd(6'h1c); chk(d, 32'h0000_0000);
    wr(6'h18, 32'h0000_00ff); chk(32'(r), 32'h0000_0002);
    rd(6'h2c); chk(d, 32'h0000_0000);
    chk(32'(r), 32'h0000_0002);
    // every step, drive, recirculation and integrate code, enable on and off
    for (i = 0; i < 64; i++) begin
      c = (8'($urandom) & 8'h1c) | {i[4:2], 3'b000, i[1:0]};
      en = i[5];
      wr(6'h28, {31'b0, en});
      wr(6'h00, {24'b0, c}); chk(32'(r), 32'h0000_0000);
      repeat (2) @(posedge aclk);
      e = (en) ? exp_br(c) : 8'h00;
      chk({bridge_on_b, bridge_on_a, switch_close_b, switch_close_a},
        {c[2] ? e : 8'h00, c[2] ? 8'h00 : e,
        c[2] ? exp_sw(c) : 8'h00, c[2] ? 8'h00 : exp_sw(c)});
      chk(32'(conv_reset), 32'(!c[7]));
      chk({30'b0, bridge_own_b, bridge_own_a},
        {30'b0, en & c[2], en & !c[2]});
      rd(6'h00); chk(d, {24'b0, c & 8'hf7});
    end
    wr(6'h00, 32'h0000_0080);
    repeat (20) @(posedge aclk);
    rd(6'h1c); chk(32'(d != 0), 32'h0000_0001);
    wr(6'h00, 32'h0000_0000);
    rd(6'h1c); chk(d, 32'h0000_0000);
    // short one-shot count, modulus off, raises underflow, then mask and clear
    wr(6'h24, 32'h0000_0001);
    wr(6'h10, 32'h0000_0000);
    wr(6'h14, 32'h0000_0002);
    wr(6'h04, 32'h0000_0004);
    wr(6'h04, 32'h0000_000c);
    for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge aclk);
    chk(32'(irq), 32'h0000_0001);
    wr(6'h24, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0000_0000);
    rd(6'h20); chk(d, 32'h0000_0001);
    wr(6'h20, 32'h0000_0001);
    rd(6'h20); chk(d, 32'h0000_0000);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
